// *** hw/rws_sequencer.sv ***
// reset sequencer, watchdog one-shot and vector fetch for a small core
// assumes RC oscillators and supply status arrive as asynchronous pin levels
// Behaviour
// - after power-on trigger hold core startup delay plus 18 clocks, start at 000C
// - internal reset comes only from power-on circuit, stop recovery and watchdog
// - startup timer is a one-shot counting its own RC oscillator
// - startup one-shot triggered by power good, stop recovery, watchdog, halt watchdog
// - watchdog is retriggerable one-shot resetting device at terminal count
// - watchdog idle until first refresh; later refreshes restart the count
// - watchdog counts its own RC oscillator, not the system clock
// - timeout at least 12 ms commercial, 10 ms extended grade
// - first 12 bytes hold six 16-bit vectors; code starts after
// - program memory is 1K or 2K bytes from address zero
// - watchdog reset behaves like power-on reset except that it sets wdt_cause_r
// - halt-watchdog instruction keeps watchdog running in halt, no clear
// - software-enabled watchdog pauses in stop mode
// - permanent option starts watchdog at reset exit, always running
`timescale 1ns/1ps
module rws_sequencer
#(
	parameter int STARTUP_RC_TICKS = rws_pkg::STARTUP_RC_TICKS_DEF,
	parameter int WDT_TICKS_COM = rws_pkg::WDT_TICKS_COM_DEF,
	parameter int WDT_TICKS_EXT = rws_pkg::WDT_TICKS_EXT_DEF
)
(
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic por_rc_osc,
	input wire logic wdt_rc_osc,
	input wire logic power_good,
	input wire logic stop_recovery_n,
	input wire logic perm_wdt_opt,
	input wire logic ext_temp_grade,
	input wire logic size_2k,
	input wire logic wdt_refresh,
	input wire logic halt_wdt_enable_cmd,
	input wire logic in_halt,
	input wire logic in_stop,
	input wire logic load_we,
	input wire logic [rws_pkg::PADDR_W-1:0] load_addr,
	input wire logic [7:0] load_data,
	input wire logic [rws_pkg::PADDR_W-1:0] fetch_addr,
	input wire logic vec_req,
	input wire logic [2:0] vec_idx,
	output logic core_rst_n_r,
	output logic start_r,
	output logic [15:0] start_pc_r,
	output logic watchdog_timer_on_r,
	output logic halt_watchdog_enable_r,
	output logic wdt_cause_r,
	output logic [7:0] fetch_data_r,
	output logic [15:0] vec_word_r,
	output logic vec_valid_r
);
	import rws_pkg::*;

	logic [SYN_N-1:0] syn1_r;
	logic [SYN_N-1:0] syn2_r;
	logic [SYN_N-1:0] syn3_r;
	rws_state_t state_r;
	rws_state_t state_nxt;
	logic [CNT_W-1:0] por_cnt_r;
	logic [HOLD_W-1:0] hold_cnt_r;
	logic [CNT_W-1:0] wdt_cnt_r;
	logic [CNT_W-1:0] wdt_limit;
	logic por_tick;
	logic wdt_tick;
	logic pg_rise;
	logic stop_rec;
	logic wdt_run;
	logic wdt_expire;
	logic trigger;
	logic perm;

	// ****************************************
	// pin synchronisers
	// ****************************************
	// lane 1 feeds only lane 2; edges are taken between lanes 2 and 3
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			syn1_r <= '0;
			syn2_r <= '0;
			syn3_r <= '0;
		end
		else
		begin
			syn1_r <= {ext_temp_grade, perm_wdt_opt, stop_recovery_n,
				power_good, wdt_rc_osc, por_rc_osc};
			syn2_r <= syn1_r;
			syn3_r <= syn2_r;
		end
	end

	// rising edges of the slow oscillators serve as their clocks
	assign por_tick = syn2_r[SYN_POR_RC] && !syn3_r[SYN_POR_RC];
	assign wdt_tick = syn2_r[SYN_WDT_RC] && !syn3_r[SYN_WDT_RC];
	assign pg_rise = syn2_r[SYN_PWR_GOOD] && !syn3_r[SYN_PWR_GOOD];
	assign stop_rec = !syn2_r[SYN_STOP_REC_N] && syn3_r[SYN_STOP_REC_N];
	assign perm = syn2_r[SYN_PERM_OPT];

	// grade is read live, so a strap change simply moves the limit
	assign wdt_limit = syn2_r[SYN_EXT_GRADE] ? CNT_W'(WDT_TICKS_EXT) :
		CNT_W'(WDT_TICKS_COM);

	// ****************************************
	// watchdog
	// ****************************************
	// stop pauses a software watchdog, halt does unless halt enable is set; permanent one never pauses
	assign wdt_run = watchdog_timer_on_r && wdt_tick && (perm ||
		(!in_stop && (!in_halt || halt_watchdog_enable_r)));
	assign wdt_expire = wdt_run &&
		(wdt_cnt_r >= wdt_limit - CNT_W'(1));

	// the four ways into the startup one-shot
	assign trigger = pg_rise || stop_rec || wdt_expire;

	// enable is cleared only by a reset sequence, never by an instruction
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			watchdog_timer_on_r <= 1'b0;
		else if (state_r != ST_RUN)
			watchdog_timer_on_r <= 1'b0;
		else if (trigger)
			watchdog_timer_on_r <= 1'b0;
		else if (wdt_refresh || perm)
			watchdog_timer_on_r <= 1'b1;
	end

	// halt enable has no effect until the watchdog is on
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			halt_watchdog_enable_r <= 1'b0;
		else if (state_r != ST_RUN || trigger)
			halt_watchdog_enable_r <= 1'b0;
		else if (halt_wdt_enable_cmd && watchdog_timer_on_r)
			halt_watchdog_enable_r <= 1'b1;
	end

	// refresh restarts; the halt-watchdog command leaves the count alone
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			wdt_cnt_r <= '0;
		else if (state_r != ST_RUN || wdt_refresh || wdt_expire)
			wdt_cnt_r <= '0;
		else if (wdt_run)
			wdt_cnt_r <= wdt_cnt_r + CNT_W'(1);
	end

	// ****************************************
	// reset sequencer
	// ****************************************
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			ST_POR:
				if (syn2_r[SYN_PWR_GOOD] && por_tick &&
					por_cnt_r >= CNT_W'(STARTUP_RC_TICKS - 1))
					state_nxt = ST_XTAL;
			ST_XTAL:
				if (hold_cnt_r >= HOLD_W'(XTAL_HOLD_CYCLES - 1))
					state_nxt = ST_RUN;
			ST_RUN:
				state_nxt = ST_RUN;
			default:
				state_nxt = ST_POR;
		endcase
		// any trigger or supply loss restarts the one-shot
		if (trigger || !syn2_r[SYN_PWR_GOOD])
			state_nxt = ST_POR;
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			state_r <= ST_POR;
		else
			state_r <= state_nxt;
	end

	// one-shot counts only while the supply is good
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			por_cnt_r <= '0;
		else if (state_r != ST_POR || trigger || !syn2_r[SYN_PWR_GOOD])
			por_cnt_r <= '0;
		else if (por_tick)
			por_cnt_r <= por_cnt_r + CNT_W'(1);
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			hold_cnt_r <= '0;
		else if (state_r != ST_XTAL)
			hold_cnt_r <= '0;
		else
			hold_cnt_r <= hold_cnt_r + HOLD_W'(1);
	end

	// core release and start pulse are registered from state_nxt, so they change together with state_r
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			core_rst_n_r <= 1'b0;
			start_r <= 1'b0;
			start_pc_r <= RESET_VECTOR;
		end
		else
		begin
			core_rst_n_r <= (state_nxt == ST_RUN);
			start_r <= (state_nxt == ST_RUN) && (state_r != ST_RUN);
			start_pc_r <= RESET_VECTOR;
		end
	end

	// cause flag: watchdog sets, power-good edge clears, set wins
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			wdt_cause_r <= 1'b0;
		else if (wdt_expire)
			wdt_cause_r <= 1'b1;
		else if (pg_rise)
			wdt_cause_r <= 1'b0;
	end

	// ****************************************
	// program memory and vectors
	// ****************************************
	// only six vectors exist; other indices give no valid strobe
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			vec_valid_r <= 1'b0;
		else
			vec_valid_r <= vec_req && (vec_idx <= LAST_VEC_IDX);
	end

	rws_prog_mem u_mem
	(
		.clk_sys(clk_sys),
		.size_2k(size_2k),
		.load_we(load_we && !core_rst_n_r),
		.load_addr(load_addr),
		.load_data(load_data),
		.fetch_addr(fetch_addr),
		.fetch_data_r(fetch_data_r),
		.vec_idx(vec_idx),
		.vec_word_r(vec_word_r)
	);
endmodule // rws_sequencer

// *** hw/rws_pkg.sv ***
// constants shared by the reset and watchdog sequencer and its program memory
// assumes a 100 MHz system clock and slow RC oscillators seen as pin levels
package rws_pkg;
	// ****************************************
	// clock and timing
	// ****************************************
	localparam int SYS_CLK_HZ = 100_000_000;
	localparam int XTAL_HOLD_CYCLES = 18;
	localparam int STARTUP_RC_TICKS_DEF = 16;
	localparam int WDT_RC_HZ = 1_000_000;
	localparam int WDT_TIMEOUT_COM_MS = 12;
	localparam int WDT_TIMEOUT_EXT_MS = 10;
	// least times round up to whole oscillator ticks
	localparam int WDT_TICKS_COM_DEF =
		(WDT_TIMEOUT_COM_MS * WDT_RC_HZ + 999) / 1000;
	localparam int WDT_TICKS_EXT_DEF =
		(WDT_TIMEOUT_EXT_MS * WDT_RC_HZ + 999) / 1000;
	localparam int CNT_W = 24;
	localparam int HOLD_W = 5;

	// ****************************************
	// program memory layout
	// ****************************************
	localparam int PADDR_W = 11;
	localparam int MEM_BYTES_2K = 2048;
	localparam int MEM_BYTES_1K = 1024;
	localparam int NUM_VECTORS = 6;
	localparam int VEC_AREA_BYTES = 12;
	localparam logic [15:0] RESET_VECTOR = 16'h000C;
	localparam logic [7:0] BLANK_BYTE = 8'hFF;
	localparam logic [2:0] LAST_VEC_IDX = 3'h5;

	// ****************************************
	// pin synchroniser lanes
	// ****************************************
	localparam int SYN_N = 6;
	localparam int SYN_POR_RC = 0;
	localparam int SYN_WDT_RC = 1;
	localparam int SYN_PWR_GOOD = 2;
	localparam int SYN_STOP_REC_N = 3;
	localparam int SYN_PERM_OPT = 4;
	localparam int SYN_EXT_GRADE = 5;

	typedef enum logic [2:0] {
		ST_POR = 3'b001,
		ST_XTAL = 3'b010,
		ST_RUN = 3'b100
	} rws_state_t;

	// byte address of the upper byte of vector n
	function automatic logic [PADDR_W-1:0] rws_vec_addr(input logic [2:0] n);
		rws_vec_addr = {7'h00, n, 1'b0};
	endfunction
endpackage

// *** hw/rws_prog_mem.sv ***
// one-time-programmable program store with a fetch port and a vector port
// assumes the load port is used only while the core is held in reset
`timescale 1ns/1ps
module rws_prog_mem
(
	input wire logic clk_sys,
	input wire logic size_2k,
	input wire logic load_we,
	input wire logic [rws_pkg::PADDR_W-1:0] load_addr,
	input wire logic [7:0] load_data,
	input wire logic [rws_pkg::PADDR_W-1:0] fetch_addr,
	output logic [7:0] fetch_data_r,
	input wire logic [2:0] vec_idx,
	output logic [15:0] vec_word_r
);
	import rws_pkg::*;

	logic [7:0] mem [0:MEM_BYTES_2K-1];
	logic [PADDR_W-1:0] vec_lo;

	// upper half is absent on the small variant
	function automatic logic in_range(input logic [PADDR_W-1:0] a,
		input logic big);
		in_range = big || (a < PADDR_W'(MEM_BYTES_1K));
	endfunction

	assign vec_lo = rws_vec_addr(vec_idx) | PADDR_W'(1);

	// ****************************************
	// load and read
	// ****************************************
	// no reset on the array: contents are the programmed image
	always_ff @(posedge clk_sys)
	begin
		if (load_we && in_range(load_addr, size_2k))
			mem[load_addr] <= load_data;
	end

	// fetch reads blank bytes above the fitted size
	always_ff @(posedge clk_sys)
	begin
		if (in_range(fetch_addr, size_2k))
			fetch_data_r <= mem[fetch_addr];
		else
			fetch_data_r <= BLANK_BYTE;
	end

	// even byte is upper, odd byte is lower
	always_ff @(posedge clk_sys)
	begin
		vec_word_r <= {mem[rws_vec_addr(vec_idx)], mem[vec_lo]};
	end
endmodule // rws_prog_mem

// *** verif/rws_seq_properties.sv ***
// checker on the sequencer's ports
// assumes it is bound into every rws_sequencer
`timescale 1ns/1ps
module rws_seq_checker
#(parameter int STARTUP_RC_TICKS = 4, parameter int WDT_TICKS_COM = 20,
	parameter int WDT_TICKS_EXT = 16)
(
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic perm_wdt_opt,
	input wire logic wdt_refresh,
	input wire logic halt_wdt_enable_cmd,
	input wire logic vec_req,
	input wire logic [2:0] vec_idx,
	input wire logic core_rst_n_r,
	input wire logic start_r,
	input wire logic [15:0] start_pc_r,
	input wire logic watchdog_timer_on_r,
	input wire logic halt_watchdog_enable_r,
	input wire logic wdt_cause_r,
	input wire logic vec_valid_r
);
	logic [7:0] low_cnt_r;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	// cycles held in reset; saturates so a long hold never wraps short
	always_ff @(posedge clk_sys or negedge rstn)
		if (!rstn)
			low_cnt_r <= 8'h00;
		else if (core_rst_n_r)
			low_cnt_r <= 8'h00;
		else if (low_cnt_r != 8'hFF)
			low_cnt_r <= low_cnt_r + 8'h01;
	property p_pc; start_pc_r == 16'h000C; endproperty
	a_pc: assert property (p_pc) else $error("bad start address");
	property p_hold; $rose(core_rst_n_r) |-> $past(low_cnt_r) >= 8'h12; endproperty
	a_hold: assert property (p_hold) else $error("hold too short");
	property p_pulse; start_r |-> $rose(core_rst_n_r) ##1 !start_r; endproperty
	a_pulse: assert property (p_pulse) else $error("bad start pulse");
	property p_off; $fell(watchdog_timer_on_r) |-> ##[0:1] !core_rst_n_r; endproperty
	a_off: assert property (p_off) else $error("watchdog stopped");
	property p_cause; $rose(wdt_cause_r) |-> ##[0:1] !core_rst_n_r; endproperty
	a_cause: assert property (p_cause) else $error("no reset");
	property p_on; $rose(watchdog_timer_on_r) |-> $past(wdt_refresh) ||
		perm_wdt_opt; endproperty
	a_on: assert property (p_on) else $error("enable uncaused");
	property p_halt; $rose(halt_watchdog_enable_r) |->
		$past(halt_wdt_enable_cmd) && $past(watchdog_timer_on_r); endproperty
	a_halt: assert property (p_halt) else $error("halt enable bad");
	property p_vec; vec_req && vec_idx <= 3'h5 |=> vec_valid_r; endproperty
	a_vec: assert property (p_vec) else $error("vector missing");
	c_rel: cover property ($rose(core_rst_n_r));
	c_wdt: cover property ($rose(wdt_cause_r));
	c_vec: cover property (vec_valid_r);
endmodule // rws_seq_checker
bind rws_sequencer rws_seq_checker #(.STARTUP_RC_TICKS(STARTUP_RC_TICKS),
	.WDT_TICKS_COM(WDT_TICKS_COM), .WDT_TICKS_EXT(WDT_TICKS_EXT))
	u_rws_seq_checker (.*);

// *** verif/rws_core_model.sv ***
// core model issuing watchdog refresh pulses
// assumes the bench sets the spacing; zero stops refreshing
`timescale 1ns/1ps
module rws_core_model
(
	input wire logic clk_sys,
	input wire logic core_rst_n_r,
	input wire logic [15:0] kick_gap,
	output logic wdt_refresh
);
	logic [15:0] gap_cnt_r;
	initial
	begin
		wdt_refresh = 1'b0;
		gap_cnt_r = 16'h0000;
	end
	// a held core runs no code, so no refresh while in reset
	always @(negedge clk_sys)
	begin
		wdt_refresh <= 1'b0;
		if (!core_rst_n_r || kick_gap == 16'h0000)
			gap_cnt_r <= 16'h0000;
		else if (gap_cnt_r + 16'h0001 == kick_gap)
		begin
			gap_cnt_r <= 16'h0000;
			wdt_refresh <= 1'b1;
		end
		else
			gap_cnt_r <= gap_cnt_r + 16'h0001;
	end
endmodule // rws_core_model

// *** verif/tb_reset_and_watchdog_sequencer.sv ***
// bench for the reset and watchdog sequencer
// assumes a core model that refreshes at the spacing set here
`timescale 1ns/1ps
module tb_reset_and_watchdog_sequencer;
	logic clk_sys, rstn, power_good, stop_recovery_n, perm_wdt_opt;
	logic ext_temp_grade, size_2k, halt_wdt_enable_cmd, in_halt, in_stop;
	logic load_we, vec_req, wdt_refresh, core_rst_n_r, start_r, vec_valid_r;
	logic watchdog_timer_on_r, halt_watchdog_enable_r, wdt_cause_r;
	logic [2:0] osc_cnt, vec_idx;
	logic [7:0] load_data, fetch_data_r;
	logic [10:0] load_addr, fetch_addr;
	logic [15:0] start_pc_r, vec_word_r, kick_gap;
	int err_total, checked, cyc, n;
	// both slow oscillators run free at an eighth of the clock
	wire por_rc_osc = osc_cnt[2];
	wire wdt_rc_osc = osc_cnt[2];
	rws_sequencer #(.STARTUP_RC_TICKS(4), .WDT_TICKS_COM(20),
		.WDT_TICKS_EXT(16)) u_rws_sequencer (.*);
	rws_core_model u_rws_core_model (.*);
	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	// oscillator divider and hang guard
	always @(negedge clk_sys)
	begin
		osc_cnt <= osc_cnt + 3'h1;
		cyc++;
		if (cyc == 20000)
		begin
			err_total++;
			conclude();
		end
	end
	task chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		err_total += int'(got !== exp);
		if (got !== exp)
			$display("ERROR %0t got %h want %h", $time, got, exp);
	endtask
	task chk_rng(input int lo, input int hi);
		checked++;
		err_total += int'(n < lo || n > hi);
		if (n < lo || n > hi)
			$display("ERROR %0t %0d cycles", $time, n);
	endtask
	// bounded wait for the core reset line
	task wait_core(input logic lvl);
		n = 0;
		while (core_rst_n_r !== lvl && n < 2000)
		begin
			@(negedge clk_sys);
			n++;
		end
	endtask
	task conclude;
		$display("checks %0d errors %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// image loads only while held; then power comes good
	task t_boot;
		load_we = 1'b1;
		for (int i = 0; i < 13; i++)
		begin
			load_addr = 11'(i);
			load_data = 8'hA0 + 8'(i);
			@(negedge clk_sys);
		end
		load_addr = 11'h400;
		load_data = 8'h5A;
		@(negedge clk_sys);
		load_we = 1'b0;
		power_good = 1'b1;
		wait_core(1'b1);
		chk_rng(40, 80);
		chk({15'h0, start_r}, 16'h0001);
		chk(start_pc_r, 16'h000C);
		$display("boot done");
	endtask
	// all six vectors, one past the end, then the memory edges
	task t_vec;
		for (int i = 0; i < 7; i++)
		begin
			@(negedge clk_sys);
			vec_req = 1'b1;
			vec_idx = 3'(i);
			@(negedge clk_sys);
			vec_req = 1'b0;
			chk({15'h0, vec_valid_r}, {15'h0, i < 6});
			if (i < 6)
				chk(vec_word_r, {8'hA0 + 8'(2 * i), 8'hA1 + 8'(2 * i)});
		end
		fetch_addr = 11'h00C;
		@(negedge clk_sys);
		chk({8'h00, fetch_data_r}, 16'h00AC);
		fetch_addr = 11'h400;
		@(negedge clk_sys);
		chk({8'h00, fetch_data_r}, 16'h005A);
		size_2k = 1'b0;
		@(negedge clk_sys);
		chk({8'h00, fetch_data_r}, 16'h00FF);
		size_2k = 1'b1;
		$display("vectors done");
	endtask
	// refresh keeps it alive; silence after a refresh times it out
	task t_wdt(input logic grade, input int lo, input int hi);
		ext_temp_grade = grade;
		kick_gap = 16'h0028;
		repeat (300) @(negedge clk_sys);
		chk({15'h0, watchdog_timer_on_r & core_rst_n_r}, 16'h0001);
		@(posedge wdt_refresh);
		@(negedge clk_sys);
		kick_gap = 16'h0000;
		wait_core(1'b0);
		chk_rng(lo, hi);
		chk({15'h0, wdt_cause_r}, 16'h0001);
		wait_core(1'b1);
		chk_rng(40, 80);
		chk({15'h0, watchdog_timer_on_r}, 16'h0000);
		$display("timeout done");
	endtask
	// halt and stop pause the count; halt stops pausing once halt running is asked for
	task t_pause;
		halt_wdt_enable_cmd = 1'b1;
		@(negedge clk_sys);
		halt_wdt_enable_cmd = 1'b0;
		kick_gap = 16'h0028;
		@(posedge wdt_refresh);
		chk({15'h0, halt_watchdog_enable_r}, 16'h0000);
		@(negedge clk_sys);
		kick_gap = 16'h0000;
		in_halt = 1'b1;
		repeat (400) @(negedge clk_sys);
		chk({15'h0, core_rst_n_r}, 16'h0001);
		in_halt = 1'b0;
		in_stop = 1'b1;
		repeat (400) @(negedge clk_sys);
		chk({15'h0, core_rst_n_r}, 16'h0001);
		in_stop = 1'b0;
		kick_gap = 16'h0028;
		halt_wdt_enable_cmd = 1'b1;
		@(negedge clk_sys);
		halt_wdt_enable_cmd = 1'b0;
		@(posedge wdt_refresh);
		chk({15'h0, halt_watchdog_enable_r}, 16'h0001);
		@(negedge clk_sys);
		kick_gap = 16'h0000;
		in_halt = 1'b1;
		wait_core(1'b0);
		chk_rng(140, 180);
		in_halt = 1'b0;
		wait_core(1'b1);
		$display("pause done");
	endtask
	// stop recovery, supply loss, then permanent watchdog through stop
	task t_trig;
		stop_recovery_n = 1'b0;
		wait_core(1'b0);
		chk_rng(1, 8);
		stop_recovery_n = 1'b1;
		wait_core(1'b1);
		chk_rng(40, 80);
		power_good = 1'b0;
		wait_core(1'b0);
		chk_rng(1, 8);
		repeat (200) @(negedge clk_sys);
		power_good = 1'b1;
		wait_core(1'b1);
		chk_rng(40, 80);
		chk({15'h0, wdt_cause_r}, 16'h0000);
		rstn = 1'b0;
		perm_wdt_opt = 1'b1;
		repeat (5) @(negedge clk_sys);
		rstn = 1'b1;
		wait_core(1'b1);
		repeat (4) @(negedge clk_sys);
		chk({15'h0, watchdog_timer_on_r}, 16'h0001);
		in_stop = 1'b1;
		wait_core(1'b0);
		chk_rng(130, 190);
		$display("triggers done");
	endtask
	initial
	begin
		{rstn, power_good, perm_wdt_opt, ext_temp_grade, in_halt} = '0;
		{halt_wdt_enable_cmd, in_stop, load_we, vec_req} = '0;
		{stop_recovery_n, size_2k, osc_cnt, vec_idx} = 8'hC0;
		{load_data, load_addr, fetch_addr, kick_gap} = '0;
		err_total = 0;
		checked = 0;
		cyc = 0;
		repeat (5) @(negedge clk_sys);
		rstn = 1'b1;
		t_boot;
		t_vec;
		t_wdt(1'b0, 140, 180);
		t_wdt(1'b1, 108, 148);
		ext_temp_grade = 1'b0;
		t_pause;
		t_trig;
		conclude();
	end
endmodule // tb_reset_and_watchdog_sequencer
